// ---- design/pslr_defines.vh ----
// pslr_defines.vh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the design files; definitions only
`ifndef PSLR_DEFINES_VH
`define PSLR_DEFINES_VH
// clock rate and wake timing
`define PSLR_CLK_PERIOD_NS      10
`define PSLR_WAKE_TO_OUTPUT_NS  20
// wake interval in clocks: 20 ns at a 10 ns period, sized for the 2-bit counter
`define PSLR_WAKE_CYCLES        2'h2
// apb register byte offsets
`define PSLR_OFF_CTRL    12'h000
`define PSLR_OFF_STATUS  12'h004
`define PSLR_OFF_MCFG    12'h008
`define PSLR_OFF_PRELOAD 12'h00C
`define PSLR_OFF_READBK  12'h010
`define PSLR_OFF_SIG_LO  12'h014
`define PSLR_OFF_SIG_HI  12'h018
`define PSLR_OFF_SECURE  12'h01C
`define PSLR_OFF_FUNC    12'h020
// ctrl fields
`define PSLR_CTRL_SLEEP_EN   0
`define PSLR_CTRL_MODE_LO    1
`define PSLR_CTRL_MODE_HI    2
// status fields
`define PSLR_ST_ASLEEP       0
`define PSLR_ST_WAKING       1
`define PSLR_ST_SECURED      2
`define PSLR_ST_PRELOAD_ERR  3
// architecture modes
`define PSLR_MODE_REG     2'h0
`define PSLR_MODE_CPLX    2'h1
`define PSLR_MODE_SIMPLE  2'h2
// macrocell kinds, two bits each in mcfg
`define PSLR_MC_REG_OUT   2'h0
`define PSLR_MC_COMB_IO   2'h1
`define PSLR_MC_COMB_OUT  2'h2
`define PSLR_MC_INPUT     2'h3
// reset values
`define PSLR_CTRL_RST     3'h0
`define PSLR_MCFG_RST     16'hFFFF
`define PSLR_SIG_RST      32'h00000000
`define PSLR_FUNC_RST     32'h00000000
`endif

// ---- design/pslr_keeper.v ----
// pslr_keeper.v: bus-hold model for the eight i/o pins
// assumes: pin level resolved outside from the enables; one clock domain
`include "pslr_defines.vh"
module pslr_keeper (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // pin sense
  input  wire [7:0] pin_in,      // level seen on the pin
  input  wire [7:0] pin_driven,  // high where some driver acts on the pin
  input  wire       hold_all,    // asleep: keep everything
  // kept level
  output reg  [7:0] pin_kept
);
  // hold the last driven level; an undriven pin never floats
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_kept <= 8'h00;
    end else begin
      pin_kept <= hold_all ? pin_kept
                           : ((pin_in & pin_driven) | (pin_kept & ~pin_driven));
    end
  end
endmodule

// ---- design/pslr_core.v ----
// pslr_core.v: eight-macrocell array shell with sleep, preload and lock
// assumes: apb master on pclk; board inputs synchronous to pclk;
// the array's sum-of-products is stood in for by a software-written table
//
// Function
// - power-up clears every macrocell register
// - sleep pin high enters held state
// - sleep freezes output data, and state except for a preload write
// - outputs tri-stated at sleep stay tri-stated
// - during sleep all other inputs ignored
// - sleep pin is logic input when disabled
// - preload forces each register high or low
// - secured device refuses readback and preload
// - 64-bit signature readable even when secured
// - pins keep last level when undriven
// - macrocell kinds: reg, comb io, comb out, input
// - three architecture modes
// - registered mode uses common clock and oe
// - outputs refresh on the third clock after wake, one past the two-clock wake interval
//
// The implementer's own choices: the APB interface to the registers and the address map.
`include "pslr_defines.vh"
module pslr_core (
  // clock, enable and reset
  input  wire        pclk,
  input  wire        pclk_en,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // board pins
  input  wire [7:0]  dedicated_in,     // plain array inputs
  input  wire        sleep_hold_pin,   // sleep control or spare input
  input  wire        array_clk,        // common register clock pin
  input  wire        array_oe_n,       // common output enable pin
  input  wire [7:0]  io_in,            // level on the eight i/o pins
  input  wire [7:0]  io_ext_drive,     // board drives the i/o pin
  output reg  [7:0]  io_out,           // macrocell output data
  output reg  [7:0]  io_oe,            // high while the cell drives its pin
  output wire [7:0]  io_kept,          // pin-keeper level
  output wire        asleep            // low-current held state
);
  // configuration state
  reg        sleep_en;        // sleep option configured
  reg [1:0]  arch_mode;       // architecture mode
  reg [15:0] mcfg;            // macrocell kinds, 2 bits per cell
  reg [31:0] sig_lo;          // user signature low word
  reg [31:0] sig_hi;          // user signature high word
  reg        secured;         // security fuse, one-way
  reg [31:0] func_tbl;        // four 4-bit input selects, cell n uses select n%4; bit 16+n inverts cell n, bit 24+n enables comb io
  reg        preload_err;     // sticky: preload refused while secured
  // array state
  reg [7:0]  mc_reg;          // macrocell registers
  reg        clk_prev;        // last sampled clock pin
  reg [7:0]  in_hold;         // inputs frozen for sleep
  reg [1:0]  wake_cnt;        // wake-to-output counter
  reg [7:0]  next_out;
  reg [7:0]  next_oe;
  reg [7:0]  next_reg;
  wire [7:0] kept;
  integer    i;

  // apb decode: zero wait states; unmapped address reports an error
  wire       acc     = psel & penable;
  wire       wr      = acc & pwrite & pclk_en;
  wire       mapped  = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0)
                       && (paddr[5:2] <= 4'h8);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // sleep request: only honoured when the option is on
  wire       sleep_req = sleep_en & sleep_hold_pin;
  assign asleep = sleep_req;
  assign io_kept = kept;

  // macrocell kind of cell n
  function [1:0] mc_kind;
    input [15:0] cfg;
    input [2:0]  n;
    begin
      mc_kind = cfg[{n, 1'b0} +: 2];
    end
  endfunction

  // array term: pick one of sixteen inputs, optional invert
  function term;
    input [15:0] vec;
    input [3:0]  sel;
    input        inv;
    begin
      term = vec[sel] ^ inv;
    end
  endfunction

  // inputs seen by the array; frozen while asleep
  // the clock and oe pins never feed the array; in simple/complex modes they are ignored
  wire [7:0] live_in = {dedicated_in[7:1],
                        sleep_en ? dedicated_in[0] : sleep_hold_pin};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_hold <= 8'h00;
    end else if (pclk_en && !sleep_req) begin
      in_hold <= live_in;
    end
  end
  wire [15:0] arr_vec = {kept, in_hold};
  wire        pin_clk = (arch_mode == `PSLR_MODE_REG) ? array_clk : 1'b0;

  // next output data and enables for every cell
  always @* begin
    next_out = 8'h00;
    next_oe  = 8'h00;
    next_reg = mc_reg;
    for (i = 0; i < 8; i = i + 1) begin
      next_reg[i] = term(arr_vec, func_tbl[(i%4)*4 +: 4], func_tbl[16+i]);
      case (mc_kind(mcfg, i[2:0]))
        `PSLR_MC_REG_OUT: begin
          next_out[i] = ~mc_reg[i];                  // inverting output buffer
          next_oe[i]  = (arch_mode == `PSLR_MODE_REG) & ~array_oe_n;
        end
        `PSLR_MC_COMB_IO: begin
          next_out[i] = next_reg[i];
          next_oe[i]  = (arch_mode != `PSLR_MODE_SIMPLE) & func_tbl[24+i];
        end
        `PSLR_MC_COMB_OUT: begin
          next_out[i] = next_reg[i];
          next_oe[i]  = 1'b1;
        end
        default: begin
          next_out[i] = 1'b0;                        // dedicated input
          next_oe[i]  = 1'b0;
        end
      endcase
    end
  end

  // macrocell registers: power-up clear, preload, array clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_reg   <= 8'h00;
      clk_prev <= 1'b0;
    end else if (pclk_en) begin
      if (wr && paddr == `PSLR_OFF_PRELOAD && !secured) begin
        mc_reg <= pwdata[7:0];
      end else if (!sleep_req) begin
        clk_prev <= pin_clk;
        if (pin_clk && !clk_prev && arch_mode == `PSLR_MODE_REG) begin
          mc_reg <= next_reg;
        end
      end
    end
  end

  // output data and enables; held at their values while asleep
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out <= 8'hFF;
      io_oe  <= 8'h00;
    end else if (pclk_en && !sleep_req && wake_cnt == 2'h0) begin
      io_out <= next_out;
      io_oe  <= next_oe;
    end
  end

  // wake counter: outputs refresh once the wake interval has run
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt <= 2'h0;
    end else if (pclk_en) begin
      if (sleep_req) begin
        wake_cnt <= `PSLR_WAKE_CYCLES;
      end else if (wake_cnt != 2'h0) begin
        wake_cnt <= wake_cnt - 2'h1;
      end
    end
  end

  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_en    <= 1'b0;
      arch_mode   <= `PSLR_MODE_REG;
      mcfg        <= `PSLR_MCFG_RST;
      sig_lo      <= `PSLR_SIG_RST;
      sig_hi      <= `PSLR_SIG_RST;
      secured     <= 1'b0;
      func_tbl    <= `PSLR_FUNC_RST;
      preload_err <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `PSLR_OFF_CTRL: begin
          if (!secured) begin
            sleep_en  <= pwdata[`PSLR_CTRL_SLEEP_EN];
            // the fourth encoding is not a mode; keep the old one
            if (pwdata[`PSLR_CTRL_MODE_HI:`PSLR_CTRL_MODE_LO] != 2'h3) begin
              arch_mode <= pwdata[`PSLR_CTRL_MODE_HI:`PSLR_CTRL_MODE_LO];
            end
          end
        end
        `PSLR_OFF_STATUS: begin
          if (pwdata[`PSLR_ST_PRELOAD_ERR]) begin
            preload_err <= 1'b0;                     // write one to clear
          end
        end
        `PSLR_OFF_MCFG: begin
          if (!secured) begin
            mcfg <= pwdata[15:0];
          end
        end
        `PSLR_OFF_PRELOAD: begin
          if (secured) begin
            preload_err <= 1'b1;
          end
        end
        `PSLR_OFF_SIG_LO: begin
          sig_lo <= pwdata;
        end
        `PSLR_OFF_SIG_HI: begin
          sig_hi <= pwdata;
        end
        `PSLR_OFF_SECURE: begin
          // one-way: once set only a reset clears it, effect immediate
          if (pwdata[0]) begin
            secured <= 1'b1;
          end
        end
        `PSLR_OFF_FUNC: begin
          if (!secured) begin
            func_tbl <= pwdata;
          end
        end
        default: begin
          secured <= secured;
        end
      endcase
    end
  end

  // read mux: configuration readback blanks once secured
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (pclk_en && psel && !penable && !pwrite) begin
      case (paddr)
        `PSLR_OFF_CTRL:    prdata <= secured ? 32'h00000000
                                    : {29'h0, arch_mode, sleep_en};
        `PSLR_OFF_STATUS:  prdata <= {28'h0, preload_err, secured,
                                     (wake_cnt != 2'h0), sleep_req};
        `PSLR_OFF_MCFG:    prdata <= secured ? 32'h00000000 : {16'h0, mcfg};
        `PSLR_OFF_READBK:  prdata <= secured ? 32'h00000000 : {24'h0, mc_reg};
        `PSLR_OFF_SIG_LO:  prdata <= sig_lo;
        `PSLR_OFF_SIG_HI:  prdata <= sig_hi;
        `PSLR_OFF_SECURE:  prdata <= {31'h0, secured};
        `PSLR_OFF_FUNC:    prdata <= secured ? 32'h00000000 : func_tbl;
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  // pin keepers on the eight i/o pins
  pslr_keeper u_keeper (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     (io_in),
    .pin_driven (io_ext_drive | io_oe),
    .hold_all   (sleep_req | ~pclk_en),
    .pin_kept   (kept)
  );
endmodule

// ---- verification/pslr_checker.sv ----
// pslr_checker: port assertions on reset, sleep hold, pin keepers and lock
// assumes: bound onto pslr_core; one clock, async active-low reset
`include "pslr_defines.vh"
module pslr_checker (
  // clock, reset and apb
  input logic        pclk, pclk_en, presetn, psel, penable, pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata, prdata,
  // pins
  input logic        asleep, sleep_hold_pin,
  input logic [7:0]  io_in, io_ext_drive, io_out, io_oe, io_kept
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic secured; // fuse rebuilt from apb writes: one-way until reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) secured <= 1'b0;
    else if (pclk_en && psel && penable && pwrite && paddr == `PSLR_OFF_SECURE)
      secured <= secured | pwdata[0];
  end
  property p_rst_clear;
    $rose(presetn) |-> $past(io_out) == 8'hFF && $past(io_oe) == 8'h00;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared");
  property p_sleep_pin;
    asleep |-> sleep_hold_pin;
  endproperty
  a_sleep_pin: assert property (p_sleep_pin) else $error("asleep without pin");
  property p_hold_data;
    asleep && $past(asleep) |-> $stable(io_out);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("output moved asleep");
  property p_hold_hiz;
    asleep && $past(asleep) |-> $stable(io_oe);
  endproperty
  a_hold_hiz: assert property (p_hold_hiz) else $error("enable moved asleep");
  property p_in_blocked;
    asleep && $past(asleep) |-> $stable(io_kept);
  endproperty
  a_in_blocked: assert property (p_in_blocked) else $error("pin taken asleep");
  property p_keep_idle;
    ((io_kept ^ $past(io_kept)) & ~$past(io_oe | io_ext_drive)) == 8'h00;
  endproperty
  a_keep_idle: assert property (p_keep_idle) else $error("keeper lost level");
  property p_keep_follow;
    !$past(asleep) && $past(pclk_en) |->
      ((io_kept ^ $past(io_in)) & $past(io_oe | io_ext_drive)) == 8'h00;
  endproperty
  a_keep_follow: assert property (p_keep_follow) else $error("keeper missed pin");
  property p_lock_readbk;
    secured && pclk_en && psel && !penable && !pwrite && paddr == `PSLR_OFF_READBK
      |=> prdata == 32'h00000000;
  endproperty
  a_lock_readbk: assert property (p_lock_readbk) else $error("readback not locked");
endmodule
bind pslr_core pslr_checker i_chk (.*);

// ---- verification/pslr_board.sv ----
// pslr_board: board side of the pins; resolves the eight i/o wires
// assumes: bench says what the board drives; pin keepers inside the device
module pslr_board (
  input  logic       pclk, presetn, clk_req,
  input  logic [7:0] drv_en, drv_val, io_out, io_oe, io_kept,
  output logic       array_clk,
  output logic [7:0] io_in, io_ext_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  assign io_ext_drive = drv_en;
  // a released wire sits at the keeper level, never a stale board value
  always_comb begin
    for (int b = 0; b < 8; b++)
      io_in[b] = io_oe[b] ? io_out[b] : drv_en[b] ? drv_val[b] : io_kept[b];
  end
  // clock source held still while the device is in reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) array_clk <= 1'b0;
    else array_clk <= clk_req;
  end
endmodule

// ---- verification/tb_pld_sleep_reset_security.sv ----
// tb_pld_sleep_reset_security: random and corner tests of the shell
// assumes: design/ on the include path; checker bound from its own file
`include "pslr_defines.vh"
module tb_pld_sleep_reset_security;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        sleep_hold_pin, array_clk, array_oe_n, asleep, clk_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, s1, s2;
  logic [31:0] seed = 32'h3B2D;
  logic [7:0]  dedicated_in, io_in, io_ext_drive, io_out, io_oe, io_kept, drv_en, drv_val, v;
  int          n_errors, n_checks;
  pslr_core i_dut (.pclk(pclk), .pclk_en(1'b1), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dedicated_in(dedicated_in),
    .sleep_hold_pin(sleep_hold_pin), .array_clk(array_clk), .array_oe_n(array_oe_n),
    .io_in(io_in), .io_ext_drive(io_ext_drive), .io_out(io_out), .io_oe(io_oe),
    .io_kept(io_kept), .asleep(asleep));
  pslr_board i_board (.pclk(pclk), .presetn(presetn), .clk_req(clk_req), .drv_en(drv_en),
    .drv_val(drv_val), .io_out(io_out), .io_oe(io_oe), .io_kept(io_kept),
    .array_clk(array_clk), .io_in(io_in), .io_ext_drive(io_ext_drive));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // a cleared register shows high at its pin, so the pin is the inverse
  function automatic logic [7:0] reg_pin(input logic [7:0] r);
    return ~r;
  endfunction
  task automatic chk(input logic [31:0] g, w);
    n_checks++;
    if (g !== w) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, w);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] w);
    apb(1'b0, a, 32'h00000000);
    chk(q, w);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {psel, penable, pwrite, sleep_hold_pin, array_oe_n, clk_req} = 6'h00;
    {paddr, pwdata, dedicated_in, drv_en, drv_val} = '0;
    presetn = 1'b0;
    cyc(12);
    chk(io_out, 8'hFF);
    chk(io_oe, 8'h00);
    presetn <= 1'b1;
    rd(`PSLR_OFF_MCFG, `PSLR_MCFG_RST);
    rd(12'h0FC, 32'h00000000);
    chk(e, 1'b1);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, `PSLR_OFF_CTRL, m << 1);
      rd(`PSLR_OFF_CTRL, m << 1);
    end
    $display("test reset and modes done");
    apb(1'b1, `PSLR_OFF_CTRL, 32'h00000000);
    apb(1'b1, `PSLR_OFF_MCFG, 32'h00000000);
    cyc(2);
    chk(io_out, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(rnd());
      apb(1'b1, `PSLR_OFF_PRELOAD, v);
      rd(`PSLR_OFF_READBK, v);
      cyc(3);
      chk(io_out, reg_pin(v));
      chk(io_oe, 8'hFF);
    end
    array_oe_n <= 1'b1;
    cyc(3);
    chk(io_oe, 8'h00);
    $display("test preload done");
    apb(1'b1, `PSLR_OFF_CTRL, 32'h00000001);
    sleep_hold_pin <= 1'b1;
    cyc(2);
    chk(asleep, 1'b1);
    {array_oe_n, clk_req, dedicated_in} <= {2'b01, 8'(rnd())};
    cyc(2);
    clk_req <= 1'b0;
    cyc(2);
    chk(io_oe, 8'h00);
    chk(io_out, reg_pin(v));
    sleep_hold_pin <= 1'b0;
    cyc(5);
    chk(io_out, reg_pin(v));
    chk(io_oe, 8'hFF);
    apb(1'b1, `PSLR_OFF_CTRL, 32'h00000000);
    sleep_hold_pin <= 1'b1;
    cyc(2);
    chk(asleep, 1'b0);
    sleep_hold_pin <= 1'b0;
    $display("test sleep done");
    apb(1'b1, `PSLR_OFF_MCFG, 32'h0000FFFF);
    {drv_en, drv_val} <= {8'hFF, 8'(rnd())};
    cyc(3);
    v = drv_val;
    {drv_en, drv_val} <= {8'h00, ~v};
    cyc(4);
    chk(io_kept, v);
    $display("test keeper done");
    s1 = rnd();
    s2 = rnd();
    apb(1'b1, `PSLR_OFF_SIG_LO, s1);
    apb(1'b1, `PSLR_OFF_SIG_HI, s2);
    apb(1'b1, `PSLR_OFF_SECURE, 32'h00000001);
    apb(1'b1, `PSLR_OFF_PRELOAD, 32'h0000005A);
    rd(`PSLR_OFF_STATUS, 32'h0000000C);
    rd(`PSLR_OFF_READBK, 32'h00000000);
    rd(`PSLR_OFF_SIG_LO, s1);
    rd(`PSLR_OFF_SIG_HI, s2);
    presetn <= 1'b0;
    cyc(2);
    chk(io_out, 8'hFF);
    presetn <= 1'b1;
    rd(`PSLR_OFF_STATUS, 32'h00000000);
    $display("test lock done");
    tally_and_finish();
  end
endmodule
